// file: design/dampt_ctrl.sv
// dram address multiplexer and column pitch timing with axi4-lite registers
//
// Local design decisions: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ns
module dampt_ctrl (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire dampt_pkg::dampt_req_t req,
    input wire logic req_valid,
    output logic req_ready,
    output logic req_done,
    output logic [21:0] dram_addr,
    output logic ras_n,
    output logic cas_n,
    input wire logic wait_n
);

    // software registers
    logic [31:0] dram_area_ctrl;
    logic [31:0] wait_ctrl_first;
    logic [31:0] wait_ctrl_second;
    logic [31:0] bus_ctrl_reg;

    // axi write holding
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;

    // access engine
    dampt_pkg::dampt_state_t state;
    dampt_pkg::dampt_state_t next_state;
    dampt_pkg::dampt_req_t cur;
    logic [4:0] pos;
    logic tick;
    logic wait_meta;
    logic wait_s;
    logic [7:0] wait_cnt;
    logic [7:0] last_wait_cnt;
    logic last_long;

    // configuration fields
    wire addr_mux_enable = dram_area_ctrl[dampt_pkg::BIT_ADDR_MUX_ENABLE];
    wire row_shift_sel_lo = dram_area_ctrl[dampt_pkg::BIT_ROW_SHIFT_SEL_LO];
    wire row_shift_sel_hi = dram_area_ctrl[dampt_pkg::BIT_ROW_SHIFT_SEL_HI];
    wire col_strobe_duty_sel = dram_area_ctrl[dampt_pkg::BIT_COL_STROBE_DUTY_SEL];
    wire cpu_read_long_pitch = wait_ctrl_first[dampt_pkg::BIT_CPU_READ_LONG_PITCH];
    wire cpu_write_long_pitch = wait_ctrl_first[dampt_pkg::BIT_CPU_WRITE_LONG_PITCH];
    wire dma_read_long_pitch = wait_ctrl_second[dampt_pkg::BIT_DMA_READ_LONG_PITCH];
    wire dma_write_long_pitch = wait_ctrl_second[dampt_pkg::BIT_DMA_WRITE_LONG_PITCH];
    wire dram_area_enable = bus_ctrl_reg[dampt_pkg::BIT_DRAM_AREA_ENABLE];

    // axi write decode
    wire do_write = aw_held && w_held;
    wire wr_dcr = aw_addr == dampt_pkg::OFS_DRAM_AREA_CTRL;
    wire wr_wc1 = aw_addr == dampt_pkg::OFS_WAIT_CTRL_FIRST;
    wire wr_wc2 = aw_addr == dampt_pkg::OFS_WAIT_CTRL_SECOND;
    wire wr_bcr = aw_addr == dampt_pkg::OFS_BUS_CTRL_REG;
    wire wr_sts = aw_addr == dampt_pkg::OFS_STATUS;
    wire wr_hit = wr_dcr || wr_wc1 || wr_wc2 || wr_bcr || wr_sts;
    wire [31:0] wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};

    // axi read decode
    wire rd_take = s_axi_arvalid && s_axi_arready;
    wire [31:0] status_word = {13'h0000, last_wait_cnt, last_long, 5'h00,
        3'(state), dram_area_enable, state != dampt_pkg::ST_IDLE};
    wire rd_dcr = s_axi_araddr == dampt_pkg::OFS_DRAM_AREA_CTRL;
    wire rd_wc1 = s_axi_araddr == dampt_pkg::OFS_WAIT_CTRL_FIRST;
    wire rd_wc2 = s_axi_araddr == dampt_pkg::OFS_WAIT_CTRL_SECOND;
    wire rd_bcr = s_axi_araddr == dampt_pkg::OFS_BUS_CTRL_REG;
    wire rd_sts = s_axi_araddr == dampt_pkg::OFS_STATUS;
    wire rd_hit = rd_dcr || rd_wc1 || rd_wc2 || rd_bcr || rd_sts;
    wire [31:0] rd_word = rd_dcr ? dram_area_ctrl :
                          rd_wc1 ? wait_ctrl_first :
                          rd_wc2 ? wait_ctrl_second :
                          rd_bcr ? bus_ctrl_reg :
                          rd_sts ? status_word : 32'h0000_0000;

    // handshake readiness
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    // write channel capture, either order
    always_ff @(posedge aclk) begin
        if (!aresetn || do_write) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
            end
        end
    end

    // write payloads, no reset needed
    always_ff @(posedge aclk) begin
        if (s_axi_awvalid && s_axi_awready) begin
            aw_addr <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end
    end

    // write response, slverr on unmapped offset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= dampt_pkg::RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? dampt_pkg::RESP_OKAY : dampt_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // register update under byte strobes; status is read only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dram_area_ctrl <= dampt_pkg::RST_DRAM_AREA_CTRL;
            wait_ctrl_first <= dampt_pkg::RST_WAIT_CTRL;
            wait_ctrl_second <= dampt_pkg::RST_WAIT_CTRL;
            bus_ctrl_reg <= dampt_pkg::RST_BUS_CTRL_REG;
        end else if (do_write) begin
            if (wr_dcr) begin
                dram_area_ctrl <= (dram_area_ctrl & ~wmask) | (w_data & wmask & 32'h0000_000f);
            end
            if (wr_wc1) begin
                wait_ctrl_first <= (wait_ctrl_first & ~wmask) | (w_data & wmask & 32'h0000_0003);
            end
            if (wr_wc2) begin
                wait_ctrl_second <= (wait_ctrl_second & ~wmask) | (w_data & wmask & 32'h0000_0003);
            end
            if (wr_bcr) begin
                bus_ctrl_reg <= (bus_ctrl_reg & ~wmask) | (w_data & wmask & 32'h0000_0001);
            end
        end
    end

    // read response one cycle after address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= dampt_pkg::RESP_OKAY;
        end else if (rd_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_hit ? dampt_pkg::RESP_OKAY : dampt_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // wait pin synchroniser
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wait_meta <= 1'b1;
            wait_s <= 1'b1;
        end else begin
            wait_meta <= wait_n;
            wait_s <= wait_meta;
        end
    end

    // accesses only while the dram area is enabled
    wire start = req_valid && req_ready;
    assign req_ready = (state == dampt_pkg::ST_IDLE) && dram_area_enable;

    // per cycle-type pitch selection
    wire long_p = (cur.kind == dampt_pkg::KIND_CPU_RD) ? cpu_read_long_pitch :
                  (cur.kind == dampt_pkg::KIND_CPU_WR) ? cpu_write_long_pitch :
                  (cur.kind == dampt_pkg::KIND_DMA_RD) ? dma_read_long_pitch :
                  dma_write_long_pitch;

    dampt_state_tick #(
        .LAST(dampt_pkg::STATE_LAST)
    ) u_tick (
        .aclk(aclk),
        .aresetn(aresetn),
        .restart(start),
        .pos(pos),
        .tick(tick)
    );

    // state sequencing: row, then one or two column states plus waits
    always_comb begin
        next_state = state;
        case (state)
            dampt_pkg::ST_IDLE: begin
                if (start) begin
                    next_state = dampt_pkg::ST_ROW;
                end
            end
            dampt_pkg::ST_ROW: begin
                if (tick) begin
                    next_state = dampt_pkg::ST_COL1;
                end
            end
            dampt_pkg::ST_COL1: begin
                if (tick && !long_p) begin
                    next_state = dampt_pkg::ST_IDLE;
                end else if (tick) begin
                    next_state = wait_s ? dampt_pkg::ST_COL2 : dampt_pkg::ST_WAIT;
                end
            end
            dampt_pkg::ST_WAIT: begin
                if (tick && wait_s) begin
                    next_state = dampt_pkg::ST_COL2;
                end
            end
            dampt_pkg::ST_COL2: begin
                if (tick) begin
                    next_state = dampt_pkg::ST_IDLE;
                end
            end
            default: begin
                next_state = dampt_pkg::ST_IDLE;
            end
        endcase
    end

    // state register and request capture
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= dampt_pkg::ST_IDLE;
            cur <= '0;
        end else begin
            state <= next_state;
            if (start) begin
                cur <= req;
            end
        end
    end

    // wait-state accounting for status
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wait_cnt <= 8'h00;
            last_wait_cnt <= 8'h00;
            last_long <= 1'b0;
        end else if (start) begin
            wait_cnt <= 8'h00;
        end else if (state == dampt_pkg::ST_WAIT && tick && wait_cnt != 8'hff) begin
            wait_cnt <= wait_cnt + 8'h01;
        end else if (state != dampt_pkg::ST_IDLE && next_state == dampt_pkg::ST_IDLE) begin
            last_wait_cnt <= wait_cnt;
            last_long <= long_p;
        end
    end

    // row address candidates; bits above the row range are driven low
    wire [21:0] row8 = {6'h00, cur.addr[23:8]};
    wire [21:0] row9 = {7'h00, cur.addr[23:9]};
    wire [21:0] row10 = {8'h00, cur.addr[23:10]};
    // reserved shift code behaves as the 10 bit shift
    wire [21:0] row_shifted = !row_shift_sel_hi && !row_shift_sel_lo ? row8 :
                              !row_shift_sel_hi ? row9 : row10;
    wire [21:0] row_addr = addr_mux_enable ? row_shifted : cur.addr[21:0];
    wire [21:0] col_addr = cur.addr[21:0];

    // column strobe high time in short pitch
    wire [4:0] duty_cyc = col_strobe_duty_sel ? dampt_pkg::DUTY_SHORT_CYC
                                              : dampt_pkg::DUTY_HALF_CYC;
    wire in_col = state == dampt_pkg::ST_COL1 || state == dampt_pkg::ST_WAIT ||
                  state == dampt_pkg::ST_COL2;
    wire cas_high = !in_col || (state == dampt_pkg::ST_COL1 && (long_p || pos < duty_cyc));

    // registered pin drive, one cycle behind the state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dram_addr <= 22'h000000;
            ras_n <= 1'b1;
            cas_n <= 1'b1;
            req_done <= 1'b0;
        end else begin
            dram_addr <= in_col ? col_addr : row_addr;
            ras_n <= state == dampt_pkg::ST_IDLE;
            cas_n <= cas_high;
            req_done <= state != dampt_pkg::ST_IDLE && next_state == dampt_pkg::ST_IDLE;
        end
    end

    // helper: cycles spent in the column phase
    logic [11:0] col_cnt;
    always_ff @(posedge aclk) begin
        if (!aresetn || !in_col) begin
            col_cnt <= 12'h000;
        end else if (col_cnt != 12'hfff) begin
            col_cnt <= col_cnt + 12'h001;
        end
    end

    default clocking dampt_cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence row_state_s;
        state == dampt_pkg::ST_ROW;
    endsequence

    sequence col_entry_s;
        state == dampt_pkg::ST_ROW && tick ##1 state == dampt_pkg::ST_COL1;
    endsequence

    req_gate_a: assert property (!dram_area_enable |-> !req_ready)
        else $error("request accepted with dram area disabled");

    no_mux_a: assert property (row_state_s and !addr_mux_enable |=>
        dram_addr == $past(cur.addr[21:0]))
        else $error("row phase without multiplexing not plain address");

    row_shift_a: assert property (row_state_s and addr_mux_enable && !row_shift_sel_hi &&
        !row_shift_sel_lo |=> dram_addr[15:0] == $past(cur.addr[23:8]))
        else $error("8 bit row shift wrong");

    col_addr_a: assert property (in_col |=> dram_addr == $past(cur.addr[21:0]))
        else $error("column address not unshifted");

    short_len_a: assert property (state == dampt_pkg::ST_COL1 && !long_p && tick |->
        col_cnt == 12'(dampt_pkg::STATE_CYC - 1) ##1 state == dampt_pkg::ST_IDLE)
        else $error("short pitch column not one state");

    long_len_a: assert property (state == dampt_pkg::ST_COL2 && tick |->
        col_cnt == 12'(2 * dampt_pkg::STATE_CYC - 1) + 12'(wait_cnt) *
        12'(dampt_pkg::STATE_CYC))
        else $error("long pitch column length wrong");

    duty_high_a: assert property (col_entry_s ##0 !long_p && pos < duty_cyc |=> cas_n)
        else $error("column strobe low too early");

    duty_low_a: assert property (state == dampt_pkg::ST_COL1 && !long_p &&
        pos >= duty_cyc |=> !cas_n)
        else $error("column strobe high too long");

    wait_sample_a: assert property (state == dampt_pkg::ST_COL1 && long_p && tick &&
        !wait_s |=> state == dampt_pkg::ST_WAIT)
        else $error("wait low not inserted");

    wait_exit_a: assert property (state == dampt_pkg::ST_WAIT && tick && wait_s |=>
        state == dampt_pkg::ST_COL2)
        else $error("wait release not taken");

    ras_first_a: assert property ($fell(cas_n) |-> !ras_n && !$past(ras_n))
        else $error("column strobe before row strobe");

endmodule

// file: design/dampt_pkg.sv
// constants, types and register map for the dram address mux and pitch timing block
// Functional notes
// - multiplex enable set: row then column address share the same address pins
// - two-bit shift select picks 8, 9 or 10 bit right shift for row
// - 8-bit shift: internal address 23..8 appears on pins 15..0 in row phase
// - row phase pins above shifted range carry no defined value
// - column phase drives internal address 21..0 unshifted on pins 21..0
// - pitch chosen per cycle type: cpu bits in first, dma in second register
// - pitch bit zero: short pitch, column address lasts exactly one state
// - pitch bit one: long pitch, column address lasts two states
// - column strobe high duty selectable 50 or 35 percent, short pitch only
// - duty bit one gives 35 percent high time, zero gives 50 percent
// - dram interface works only while dram area enable bit is one
// - long pitch samples wait before second column state; low inserts wait states
package dampt_pkg;

    // clock and state timing
    localparam int unsigned CLK_MHZ = 250;
    localparam int unsigned STATE_NS = 80;
    localparam int unsigned STATE_CYC = STATE_NS * CLK_MHZ / 1000;
    localparam int unsigned DUTY_HALF_PCT = 50;
    localparam int unsigned DUTY_SHORT_PCT = 35;
    localparam logic [4:0] STATE_LAST = 5'(STATE_CYC - 1);
    localparam logic [4:0] DUTY_HALF_CYC = 5'(STATE_CYC * DUTY_HALF_PCT / 100);
    localparam logic [4:0] DUTY_SHORT_CYC = 5'(STATE_CYC * DUTY_SHORT_PCT / 100);

    // register byte offsets
    localparam logic [7:0] OFS_DRAM_AREA_CTRL = 8'h00;
    localparam logic [7:0] OFS_WAIT_CTRL_FIRST = 8'h04;
    localparam logic [7:0] OFS_WAIT_CTRL_SECOND = 8'h08;
    localparam logic [7:0] OFS_BUS_CTRL_REG = 8'h0c;
    localparam logic [7:0] OFS_STATUS = 8'h10;

    // field positions
    localparam int unsigned BIT_ADDR_MUX_ENABLE = 0;
    localparam int unsigned BIT_ROW_SHIFT_SEL_LO = 1;
    localparam int unsigned BIT_ROW_SHIFT_SEL_HI = 2;
    localparam int unsigned BIT_COL_STROBE_DUTY_SEL = 3;
    localparam int unsigned BIT_CPU_READ_LONG_PITCH = 0;
    localparam int unsigned BIT_CPU_WRITE_LONG_PITCH = 1;
    localparam int unsigned BIT_DMA_READ_LONG_PITCH = 0;
    localparam int unsigned BIT_DMA_WRITE_LONG_PITCH = 1;
    localparam int unsigned BIT_DRAM_AREA_ENABLE = 0;

    // reset values
    localparam logic [31:0] RST_DRAM_AREA_CTRL = 32'h0000_0000;
    localparam logic [31:0] RST_WAIT_CTRL = 32'h0000_0000;
    localparam logic [31:0] RST_BUS_CTRL_REG = 32'h0000_0000;

    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        KIND_CPU_RD,
        KIND_CPU_WR,
        KIND_DMA_RD,
        KIND_DMA_WR
    } dampt_kind_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ROW,
        ST_COL1,
        ST_WAIT,
        ST_COL2
    } dampt_state_t;

    typedef struct packed {
        logic [23:0] addr;
        dampt_kind_t kind;
    } dampt_req_t;

endpackage

// file: design/dampt_state_tick.sv
// state divider: position within a bus state and a pulse on its last cycle
`timescale 1ns/1ns
module dampt_state_tick #(
    parameter logic [4:0] LAST = 5'h13
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic restart,
    output logic [4:0] pos,
    output logic tick
);

    // pulse on the last cycle of each state
    assign tick = (pos == LAST);

    // restart aligns a new access to the start of a state
    always_ff @(posedge aclk) begin
        if (!aresetn || restart || tick) begin
            pos <= 5'h00;
        end else begin
            pos <= pos + 5'h01;
        end
    end

endmodule

// file: test/dampt_dram_model.sv
// dram side model: latches row and column addresses and drives the wait pin
`timescale 1ns/1ns
module dampt_dram_model (
    input wire logic aclk,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic [21:0] dram_addr,
    input wire logic [1:0] waits,
    output logic wait_n,
    output logic [21:0] row_seen,
    output logic [21:0] col_seen,
    output logic [7:0] ras_to_cas,
    output logic [7:0] cas_low
);
    logic ras_d = 1'b1;
    logic cas_d = 1'b1;
    logic [7:0] cnt = 8'h00;
    logic [7:0] hold = 8'h00;

    // wait pin has a pull-up: high whenever the model is not holding it low
    assign wait_n = (hold == 8'h00);

    // row latched at row strobe fall, column at column strobe fall under row strobe
    always @(posedge aclk) begin
        ras_d <= ras_n;
        cas_d <= cas_n;
        cnt <= cnt + 8'h01;
        if (ras_d && !ras_n) begin
            row_seen <= dram_addr;
            cnt <= 8'h01;
            // low long enough to cover the given number of wait samples
            hold <= (waits == 2'h0) ? 8'h00 : 8'(dampt_pkg::STATE_CYC * (waits + 1) + 8);
        end else if (hold != 8'h00) begin
            hold <= hold - 8'h01;
        end
        if (cas_d && !cas_n && !ras_n) begin
            col_seen <= dram_addr;
            ras_to_cas <= cnt;
            cas_low <= 8'h01;
        end else if (!cas_n) begin
            cas_low <= cas_low + 8'h01;
        end
    end
endmodule

// file: test/tb_dram_addr_mux_pitch_timing.sv
// self-checking bench for the dram address mux and pitch timing block
`timescale 1ns/1ns
module tb_dram_addr_mux_pitch_timing;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, req_ready, req_done, ras_n, cas_n, wait_n;
    logic [1:0] bresp, rresp, rsp, shs, waits = 2'h0;
    dampt_pkg::dampt_req_t req = '0;
    dampt_pkg::dampt_req_t q;
    logic req_valid = 1'b0;
    logic [21:0] dram_addr, row_seen, col_seen;
    logic [7:0] ras_to_cas, cas_low;
    logic mux, duty, lng;
    logic [31:0] seed = 32'h0000e639;
    logic [31:0] r;
    int err_total = 0;
    int checks = 0;
    int cyc = 0;

    dampt_ctrl u_dampt_ctrl (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .req(req), .req_valid(req_valid), .req_ready(req_ready),
        .req_done(req_done), .dram_addr(dram_addr), .ras_n(ras_n), .cas_n(cas_n),
        .wait_n(wait_n));
    dampt_dram_model u_dampt_dram_model (.aclk(aclk), .ras_n(ras_n), .cas_n(cas_n),
        .dram_addr(dram_addr), .waits(waits), .wait_n(wait_n), .row_seen(row_seen),
        .col_seen(col_seen), .ras_to_cas(ras_to_cas), .cas_low(cas_low));

    // 250 MHz clock
    initial begin
        forever #2 aclk = ~aclk;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // expected row pins and which of them are defined
    function automatic logic [21:0] exp_row(logic [23:0] a, logic m, logic [1:0] s);
        return m ? 22'(a >> (8 + s)) : a[21:0];
    endfunction
    function automatic logic [21:0] row_mask(logic m, logic [1:0] s);
        return m ? 22'((24'h1 << (16 - s)) - 24'h1) : 22'h3fffff;
    endfunction
    // pitch bits: the chosen kind gets l, every other kind the opposite
    function automatic logic [31:0] pitch(logic sel, logic [1:0] k, logic l);
        logic [1:0] v;
        v = {2{~l}};
        if (k[1] == sel) v[k[0]] = l;
        return {30'h0, v};
    endfunction

    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // axi4-lite write: address and data offered together, each dropped once taken
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
        logic at, wt, bt;
        bt = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wstrb <= 4'hf;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!bt) begin
            @(negedge aclk);
            at = awvalid && (awready === 1'b1);
            wt = wvalid && (wready === 1'b1);
            bt = (bvalid === 1'b1);
            rs = bresp;
            @(posedge aclk);
            if (at) awvalid <= 1'b0;
            if (wt) wvalid <= 1'b0;
            if (bt) bready <= 1'b0;
        end
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
        logic at, rt;
        rt = 1'b0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!rt) begin
            @(negedge aclk);
            at = arvalid && (arready === 1'b1);
            rt = (rvalid === 1'b1);
            d = rdata;
            rs = rresp;
            @(posedge aclk);
            if (at) arvalid <= 1'b0;
            if (rt) rready <= 1'b0;
        end
    endtask

    // one dram access with the far side asking for w wait samples
    task automatic run_access(input dampt_pkg::dampt_req_t qq, input logic [1:0] w);
        int n;
        logic [7:0] hi;
        @(posedge aclk);
        req <= qq;
        req_valid <= 1'b1;
        waits <= w;
        n = 0;
        do begin @(negedge aclk); n++; end while (req_ready !== 1'b1 && n < 50);
        @(posedge aclk);
        req_valid <= 1'b0;
        n = 0;
        do begin @(negedge aclk); n++; end while (req_done !== 1'b1 && n < 400);
        hi = lng ? 8'(dampt_pkg::STATE_CYC) :
            8'(duty ? dampt_pkg::DUTY_SHORT_CYC : dampt_pkg::DUTY_HALF_CYC);
        check("latency", n, lng ? (3 + w) * dampt_pkg::STATE_CYC + 1 :
            2 * dampt_pkg::STATE_CYC + 1);
        @(negedge aclk);
        check("done pulse", req_done, 1'b0);
        @(negedge aclk);
        check("row", row_seen & row_mask(mux, shs),
            exp_row(qq.addr, mux, shs) & row_mask(mux, shs));
        check("column", col_seen, qq.addr[21:0]);
        check("cas high", ras_to_cas, dampt_pkg::STATE_CYC + hi);
        check("cas low", cas_low, lng ? (w + 1) * dampt_pkg::STATE_CYC :
            dampt_pkg::STATE_CYC - hi);
    endtask

    // hang guard
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 60000) begin
            err_total++;
            tally_and_finish();
        end
    end

    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(negedge aclk);
        check("ready off", req_ready, 1'b0);
        for (int i = 0; i < 5; i++) begin
            rd_reg(8'(4 * i), rd, rsp);
            check("reset value", rd, 32'h0);
            check("reset resp", rsp, dampt_pkg::RESP_OKAY);
        end
        rd_reg(8'h20, rd, rsp);
        check("unmapped read", {rsp, rd[29:0]}, {dampt_pkg::RESP_SLVERR, 30'h0});
        wr_reg(8'h20, 32'h1, rsp);
        check("unmapped write", rsp, dampt_pkg::RESP_SLVERR);
        wr_reg(dampt_pkg::OFS_BUS_CTRL_REG, 32'h1, rsp);
        for (int i = 0; i < 36; i++) begin
            r = rnd();
            mux = r[0] | r[1];
            shs = (r[3:2] == 2'h3) ? 2'h2 : r[3:2];
            duty = r[4];
            lng = r[5];
            q.kind = dampt_pkg::dampt_kind_t'(2'(i));
            q.addr = (i == 0) ? 24'hffffff : (i == 1) ? 24'h0 : 24'(rnd() >> 8);
            wr_reg(dampt_pkg::OFS_DRAM_AREA_CTRL, {28'h0, duty, shs, mux}, rsp);
            wr_reg(dampt_pkg::OFS_WAIT_CTRL_FIRST, pitch(1'b0, q.kind, lng), rsp);
            wr_reg(dampt_pkg::OFS_WAIT_CTRL_SECOND, pitch(1'b1, q.kind, lng), rsp);
            rd_reg(dampt_pkg::OFS_DRAM_AREA_CTRL, rd, rsp);
            check("ctrl readback", rd, {28'h0, duty, shs, mux});
            run_access(q, 2'(r[7:6] % 3));
            // status keeps the pitch and wait count of the access just ended
            rd_reg(dampt_pkg::OFS_STATUS, rd, rsp);
            check("status", rd, {13'h0, lng ? 8'(r[7:6] % 3) : 8'h00, lng, 10'h002});
        end
        wr_reg(dampt_pkg::OFS_BUS_CTRL_REG, 32'h0, rsp);
        @(negedge aclk);
        check("ready off", req_ready, 1'b0);
        tally_and_finish();
    end
endmodule
